// ### include/bmu_pkg.sv
// Shared constants and carriers for the bit-manipulation read-modify-write unit.
// Assumes one 50 MHz clock and a byte-wide on-chip bus with 16-bit addresses.
package bmu_pkg;
	// Form codes carried in bits 15:12 of the first instruction word
	localparam logic [3:0] FORM_REG_IMM = 4'h7;
	localparam logic [3:0] FORM_REG_REG = 4'h6;
	localparam logic [3:0] FORM_IND = 4'hc;
	localparam logic [3:0] FORM_ABS = 4'he;
	// Bit-number source code in bits 15:12 of the second word
	localparam logic [3:0] SRC_IMM = 4'h7;
	localparam logic [3:0] SRC_REG = 4'h6;
	// Operation codes carried in bits 11:8 of each word
	localparam logic [3:0] OPC_SET = 4'h0;
	localparam logic [3:0] OPC_CLR = 4'h1;
	localparam logic [3:0] OPC_INV = 4'h2;
	localparam logic [3:0] OPC_TST = 4'h3;
	localparam logic [3:0] OPC_AND = 4'h4;
	localparam logic [3:0] OPC_OR = 4'h5;
	localparam logic [3:0] OPC_XOR = 4'h6;
	localparam logic [3:0] OPC_LD = 4'h7;
	localparam logic [3:0] OPC_ST = 4'h8;
	localparam logic [3:0] OPC_IAND = 4'h9;
	localparam logic [3:0] OPC_IOR = 4'ha;
	localparam logic [3:0] OPC_IXOR = 4'hb;
	localparam logic [3:0] OPC_ILD = 4'hc;
	localparam logic [3:0] OPC_IST = 4'hd;
	// First code that only takes an immediate bit number
	localparam logic [3:0] OPC_FIRST_CARRY = 4'h4;
	// Upper address byte of the 8-bit absolute area
	localparam logic [7:0] ABS_PAGE = 8'hff;
	// Port registers inside the absolute area
	localparam logic [15:0] PORT_LATCH_ADDR = 16'hffb7;
	localparam logic [15:0] PORT_DIR_ADDR = 16'hffb5;
	localparam logic [7:0] PORT_LATCH_RST = 8'h00;
	localparam logic [7:0] PORT_DIR_RST = 8'h00;
	// Value returned when a write-only register is read
	localparam logic [7:0] WO_READ_VAL = 8'hff;

	// Request carried to the on-chip bus
	typedef struct packed {
		logic [15:0] addr;
		logic rd;
		logic wr;
		logic [7:0] wdata;
	} bmu_bus_req_s;
endpackage

// ### hw/bmu_port.sv
// Port with output latch and write-only direction register.
// Assumes accesses come from the unit's own bus request, one byte at a time.
`timescale 1ns/1ps
`default_nettype none
module bmu_port
	import bmu_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire bmu_bus_req_s req_i,
	output logic hit_o,
	output logic [7:0] rdata_o,
	input wire logic [7:0] pin_i,
	output logic [7:0] pin_o,
	output logic [7:0] pin_oe_o,
	output logic [7:0] pullup_o
);
	logic [7:0] latch_q; // Output latch
	logic [7:0] dir_q; // Direction, one means output
	wire hit_latch = (req_i.addr == PORT_LATCH_ADDR);
	wire hit_dir = (req_i.addr == PORT_DIR_ADDR);
	// Input pins show their level, output pins the latch
	wire [7:0] latch_view = (dir_q & latch_q) | (~dir_q & pin_i);

	assign hit_o = hit_latch | hit_dir;
	// The direction register cannot be read back; it shows all ones
	assign rdata_o = hit_dir ? WO_READ_VAL : latch_view;
	assign pin_o = latch_q;
	assign pin_oe_o = dir_q;
	// Latch bit of an input pin steers its pull-up
	assign pullup_o = ~dir_q & latch_q;

	// Register writes
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
		begin
			latch_q <= PORT_LATCH_RST;
			dir_q <= PORT_DIR_RST;
		end
		else if (req_i.wr)
		begin
			if (hit_latch)
				latch_q <= req_i.wdata;
			if (hit_dir)
				dir_q <= req_i.wdata;
		end
	end
endmodule
`default_nettype wire

// ### hw/bmu_core.sv
// Decoder and sequencer for single-bit manipulation instructions, with the port.
// Assumes an instruction word stream with valid/ready, a general register file
// with combinational read, and a bus slave that answers with an ack.
// Notes on behaviour
// - Input pins read their live pin level
// - Output pins read their output latch value
// - Set bit reads, sets bit, writes byte back
// - Input pin latch bit switches its pull-up
// - Register form: op 15:8, bit 7:4, reg 3:0
// - Register bit number uses low three bits
// - Indirect and absolute forms use two words
// - Set/clear/invert/test take immediate or register bit
// - Carry ops take immediate bit number only
// - Inverted carry ops also immediate only
// - Write-only register reads back as all ones
`timescale 1ns/1ps
`default_nettype none
module bmu_core
	import bmu_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic instr_valid_i,
	input wire logic [15:0] instr_i,
	output logic instr_ready_o,
	output logic done_o,
	output logic illegal_o,
	output logic [2:0] gr_rsel_o,
	input wire logic [15:0] gr_rdata_i,
	output logic gr_we_o,
	output logic [3:0] gr_wsel_o,
	output logic [7:0] gr_wdata_o,
	input wire logic carry_i,
	output logic carry_we_o,
	output logic carry_o,
	output logic zero_we_o,
	output logic zero_o,
	output bmu_bus_req_s bus_req_o,
	input wire logic [7:0] bus_rdata_i,
	input wire logic bus_ack_i,
	input wire logic [7:0] pin_i,
	output logic [7:0] pin_o,
	output logic [7:0] pin_oe_o,
	output logic [7:0] pullup_o
);
	typedef enum logic [2:0] {S_IDLE, S_WORD2, S_BITREG, S_OPND, S_RD, S_EXEC, S_WR}
		bmu_state_e;

	bmu_state_e state_q;
	logic [15:0] w1_q; // First word of the instruction
	logic [3:0] rm_q; // Register holding the bit number
	logic [2:0] bit_q; // Bit position in use
	logic [15:0] addr_q; // Target address of a memory operand
	logic [7:0] data_q; // Fetched byte
	logic [7:0] wdata_q; // Byte being written back
	logic done_q, illegal_q, gr_we_q, c_we_q, c_q, z_we_q, z_q;
	logic [7:0] gr_wdata_q;

	// Field split of the incoming word
	wire [3:0] in_form = instr_i[15:12];
	wire [3:0] in_opc = instr_i[11:8];
	wire [3:0] in_mid = instr_i[7:4];
	wire [3:0] in_low = instr_i[3:0];
	wire in_take = instr_valid_i & instr_ready_o;
	wire in_carry_op = (in_opc >= OPC_FIRST_CARRY);
	wire in_bad_opc = (in_opc > OPC_IST);
	// Immediate bit numbers are three bits; the top bit of the field must be zero
	wire in_bad_imm = in_mid[3];
	// Register bit source is refused for carry operations
	wire in_bad_reg = in_carry_op;

	// Fields of the latched first word
	wire [3:0] form = w1_q[15:12];
	wire [3:0] opc = w1_q[11:8];
	wire [3:0] rn = w1_q[3:0];
	wire is_reg = (form == FORM_REG_IMM) | (form == FORM_REG_REG);

	// Byte pick from a general register: code bit 3 picks the low byte
	function automatic logic [7:0] pick_byte(input logic [3:0] code, input logic [15:0] w);
		pick_byte = code[3] ? w[7:0] : w[15:8];
	endfunction

	// First-word acceptance checks
	wire w1_bad = in_bad_opc
		| ((in_form == FORM_REG_IMM) & in_bad_imm)
		| ((in_form == FORM_REG_REG) & in_bad_reg)
		| ((in_form == FORM_IND) & (in_low != 4'h0))
		| ((in_form != FORM_REG_IMM) & (in_form != FORM_REG_REG)
			& (in_form != FORM_IND) & (in_form != FORM_ABS));
	// Second word must repeat the operation and end in zeros
	wire w2_bad = (in_opc != opc) | (in_low != 4'h0)
		| ((in_form == SRC_IMM) & in_bad_imm)
		| ((in_form == SRC_REG) & in_bad_reg)
		| ((in_form != SRC_IMM) & (in_form != SRC_REG));

	// Register read select follows the state
	assign gr_rsel_o = (state_q == S_BITREG) ? rm_q[2:0]
		: ((form == FORM_IND) ? w1_q[6:4] : rn[2:0]);
	wire [7:0] rd_byte_bit = pick_byte(rm_q, gr_rdata_i);
	wire [7:0] rd_byte_opnd = pick_byte(rn, gr_rdata_i);

	// Port sits on the same request; external strobes are held off when it answers
	bmu_bus_req_s req;
	logic port_hit;
	logic [7:0] port_rdata;
	assign req.addr = addr_q;
	assign req.rd = (state_q == S_RD);
	assign req.wr = (state_q == S_WR);
	assign req.wdata = wdata_q;
	bmu_port u_port (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.req_i(req),
		.hit_o(port_hit),
		.rdata_o(port_rdata),
		.pin_i(pin_i),
		.pin_o(pin_o),
		.pin_oe_o(pin_oe_o),
		.pullup_o(pullup_o)
	);
	assign bus_req_o.addr = addr_q;
	assign bus_req_o.rd = req.rd & ~port_hit;
	assign bus_req_o.wr = req.wr & ~port_hit;
	assign bus_req_o.wdata = wdata_q;
	wire acc_ack = port_hit | bus_ack_i;
	wire [7:0] acc_rdata = port_hit ? port_rdata : bus_rdata_i;

	// Bit arithmetic on the fetched byte
	wire [7:0] mask = 8'h01 << bit_q;
	wire sel_bit = data_q[bit_q];
	wire inv_src = (opc >= OPC_IAND);
	wire src_bit = sel_bit ^ inv_src;
	wire st_val = (opc == OPC_IST) ? ~carry_i : carry_i;
	logic [7:0] result;
	logic modifies;
	logic c_new;
	// Result and carry per operation; the byte is rewritten whole only for set, clear, invert and the stores
	always_comb
	begin
		result = data_q;
		modifies = 1'b1;
		c_new = carry_i;
		unique case (opc)
			OPC_SET: result = data_q | mask;
			OPC_CLR: result = data_q & ~mask;
			OPC_INV: result = data_q ^ mask;
			OPC_ST, OPC_IST: result = st_val ? (data_q | mask) : (data_q & ~mask);
			OPC_AND, OPC_IAND:
			begin
				modifies = 1'b0;
				c_new = carry_i & src_bit;
			end
			OPC_OR, OPC_IOR:
			begin
				modifies = 1'b0;
				c_new = carry_i | src_bit;
			end
			OPC_XOR, OPC_IXOR:
			begin
				modifies = 1'b0;
				c_new = carry_i ^ src_bit;
			end
			OPC_LD, OPC_ILD:
			begin
				modifies = 1'b0;
				c_new = src_bit;
			end
			default: modifies = 1'b0; // Test only touches the zero flag
		endcase
	end
	wire is_test = (opc == OPC_TST);
	wire is_carry = (opc >= OPC_FIRST_CARRY) & (opc != OPC_ST) & (opc != OPC_IST);

	assign instr_ready_o = (state_q == S_IDLE) | (state_q == S_WORD2);
	assign done_o = done_q;
	assign illegal_o = illegal_q;
	assign gr_we_o = gr_we_q;
	assign gr_wsel_o = rn;
	assign gr_wdata_o = gr_wdata_q;
	assign carry_we_o = c_we_q;
	assign carry_o = c_q;
	assign zero_we_o = z_we_q;
	assign zero_o = z_q;

	// Sequencer: decode, fetch bit number, fetch operand, read, modify, write
	always_ff @(posedge mclk_i)
	begin
		done_q <= 1'b0;
		illegal_q <= 1'b0;
		gr_we_q <= 1'b0;
		c_we_q <= 1'b0;
		z_we_q <= 1'b0;
		if (!rst_n_i)
		begin
			state_q <= S_IDLE;
			w1_q <= 16'h0000;
			rm_q <= 4'h0;
			bit_q <= 3'h0;
			addr_q <= 16'h0000;
			data_q <= 8'h00;
			wdata_q <= 8'h00;
			gr_wdata_q <= 8'h00;
			c_q <= 1'b0;
			z_q <= 1'b0;
		end
		else
		begin
			unique case (state_q)
				S_IDLE:
					if (in_take)
					begin
						w1_q <= instr_i;
						rm_q <= in_mid;
						bit_q <= in_mid[2:0];
						if (w1_bad)
							illegal_q <= 1'b1;
						else if ((in_form == FORM_IND) | (in_form == FORM_ABS))
							state_q <= S_WORD2;
						else if (in_form == FORM_REG_REG)
							state_q <= S_BITREG;
						else
							state_q <= S_OPND;
					end
				S_WORD2:
					if (in_take)
					begin
						rm_q <= in_mid;
						bit_q <= in_mid[2:0];
						if (w2_bad)
						begin
							illegal_q <= 1'b1;
							state_q <= S_IDLE;
						end
						else if (in_form == SRC_REG)
							state_q <= S_BITREG;
						else
							state_q <= S_OPND;
					end
				S_BITREG:
				begin
					bit_q <= rd_byte_bit[2:0];
					state_q <= S_OPND;
				end
				S_OPND:
					if (is_reg)
					begin
						data_q <= rd_byte_opnd;
						state_q <= S_EXEC;
					end
					else
					begin
						// Pointer word or page plus 8-bit absolute address
						addr_q <= (form == FORM_IND) ? gr_rdata_i : {ABS_PAGE, w1_q[7:0]};
						state_q <= S_RD;
					end
				S_RD:
					if (acc_ack)
					begin
						data_q <= acc_rdata;
						state_q <= S_EXEC;
					end
				S_EXEC:
				begin
					z_we_q <= is_test;
					z_q <= ~sel_bit;
					c_we_q <= is_carry;
					c_q <= c_new;
					if (modifies & is_reg)
					begin
						gr_we_q <= 1'b1;
						gr_wdata_q <= result;
					end
					if (modifies & ~is_reg)
					begin
						// Go straight to the write so no other access slips in
						wdata_q <= result;
						state_q <= S_WR;
					end
					else
					begin
						done_q <= 1'b1;
						state_q <= S_IDLE;
					end
				end
				S_WR:
					if (acc_ack)
					begin
						done_q <= 1'b1;
						state_q <= S_IDLE;
					end
			endcase
		end
	end
endmodule
`default_nettype wire

// ### dv/bmu_core_props.sv
// Checker for bmu_core: sees only the top module ports.
// Assumes one clock and the synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module bmu_core_props
	import bmu_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic instr_valid_i,
	input wire logic [15:0] instr_i,
	input wire logic instr_ready_o,
	input wire logic done_o,
	input wire logic illegal_o,
	input wire bmu_bus_req_s bus_req_o,
	input wire logic bus_ack_i,
	input wire logic [7:0] pin_o,
	input wire logic [7:0] pin_oe_o,
	input wire logic [7:0] pullup_o
);
	// High while the next taken word is a second word
	logic word2_q;
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	// Track pairing, since second words reuse the form codes
	always_ff @(posedge mclk_i)
		if (!rst_n_i || illegal_o)
			word2_q <= 1'b0;
		else if (instr_valid_i && instr_ready_o)
			word2_q <= !word2_q && (instr_i[15:12] == FORM_IND || instr_i[15:12] == FORM_ABS);
	// A first word taken on this edge
	sequence first_s;
		instr_valid_i && instr_ready_o && !word2_q;
	endsequence
	// A memory read that ends on this edge
	sequence rd_ack_s;
		bus_req_o.rd && bus_ack_i;
	endsequence
	reg_imm_done_a: assert property (first_s ##0 (instr_i[15:12] == FORM_REG_IMM
		&& instr_i[11:8] <= OPC_IST && !instr_i[7]) |-> ##3 done_o)
		else $error("register form did not finish in time");
	bad_opcode_a: assert property (first_s ##0 (instr_i[15:12] == FORM_REG_IMM
		&& instr_i[11:8] > OPC_IST) |=> illegal_o)
		else $error("bad op code not refused");
	imm_range_a: assert property (first_s ##0 (instr_i[15:12] == FORM_REG_IMM
		&& instr_i[7]) |=> illegal_o)
		else $error("bit number above seven not refused");
	carry_regbit_a: assert property (first_s ##0 (instr_i[15:12] == FORM_REG_REG
		&& instr_i[11:8] >= OPC_FIRST_CARRY) |=> illegal_o)
		else $error("carry op with register bit not refused");
	pullup_map_a: assert property (pullup_o == (~pin_oe_o & pin_o))
		else $error("pull-up does not follow input latch bits");
	port_local_a: assert property ((bus_req_o.addr == PORT_LATCH_ADDR
		|| bus_req_o.addr == PORT_DIR_ADDR) |-> !bus_req_o.rd && !bus_req_o.wr)
		else $error("port access leaked onto the bus");
	exec_gap_a: assert property (rd_ack_s |=> !bus_req_o.rd && !bus_req_o.wr)
		else $error("access right after read");
	write_back_a: assert property ($rose(bus_req_o.wr) |-> $past(bus_req_o.rd, 2)
		&& $past(bus_ack_i, 2) && bus_req_o.addr == $past(bus_req_o.addr, 2))
		else $error("write not tied to preceding read");
	read_hold_a: assert property (bus_req_o.rd && !bus_ack_i
		|=> bus_req_o.rd && $stable(bus_req_o.addr))
		else $error("read dropped before ack");
	done_pulse_a: assert property (done_o |=> !done_o && instr_ready_o)
		else $error("done not a single pulse");
endmodule
bind bmu_core bmu_core_props u_bmu_core_props (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
	.instr_valid_i(instr_valid_i), .instr_i(instr_i), .instr_ready_o(instr_ready_o),
	.done_o(done_o), .illegal_o(illegal_o), .bus_req_o(bus_req_o), .bus_ack_i(bus_ack_i),
	.pin_o(pin_o), .pin_oe_o(pin_oe_o), .pullup_o(pullup_o));
`default_nettype wire

// ### dv/bmu_mem_model.sv
// Byte memory on the on-chip bus with a settable number of wait states.
// Assumes the unit holds rd or wr and the address until the ack edge.
`timescale 1ns/1ps
`default_nettype none
module bmu_mem_model
	import bmu_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire bmu_bus_req_s req_i,
	input wire logic [1:0] wait_i,
	output logic [7:0] rdata_o,
	output logic ack_o
);
	logic [7:0] mem [256]; // Low address byte only, page is ignored
	logic [1:0] cnt_q; // Wait cycles spent on the current access
	assign ack_o = (req_i.rd || req_i.wr) && (cnt_q == wait_i);
	// Outside an acked read the data is garbage, never the last value
	assign rdata_o = (ack_o && req_i.rd) ? mem[req_i.addr[7:0]] : ~mem[req_i.addr[7:0]];
	// Plain process: the bench also preloads the array
	always @(posedge mclk_i)
	begin
		cnt_q <= (!rst_n_i || ack_o || !(req_i.rd || req_i.wr)) ? 2'h0 : cnt_q + 2'h1;
		if (ack_o && req_i.wr)
			mem[req_i.addr[7:0]] <= req_i.wdata;
	end
endmodule
`default_nettype wire

// ### dv/bmu_core_tb_top.sv
// Bench for bmu_core: port, memory and register forms, refusals.
// Assumes bmu_mem_model on the bus; the bench holds the register file.
`timescale 1ns/1ps
`default_nettype none
module bmu_core_tb_top import bmu_pkg::*;;
	logic mclk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic instr_valid_i = 1'b0;
	logic carry_i = 1'b1;
	logic [15:0] instr_i = 16'h0000;
	logic [7:0] pin_i = 8'h40;
	logic [1:0] wait_q = 2'h0;
	logic instr_ready_o, done_o, illegal_o, gr_we_o, carry_we_o, carry_o, zero_we_o, zero_o;
	logic bus_ack_i, c_seen, z_seen, got_ill;
	logic [2:0] gr_rsel_o;
	logic [3:0] gr_wsel_o;
	logic [7:0] gr_wdata_o, bus_rdata_i, pin_o, pin_oe_o, pullup_o;
	logic [15:0] gr_q [8];
	wire logic [15:0] gr_rdata_i;
	bmu_bus_req_s bus_req_o;
	int failures = 0;
	int total_checks = 0;
	assign gr_rdata_i = gr_q[gr_rsel_o];
	always #10 mclk_i = ~mclk_i;
	bmu_core u_bmu_core (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .instr_valid_i(instr_valid_i),
		.instr_i(instr_i), .instr_ready_o(instr_ready_o), .done_o(done_o),
		.illegal_o(illegal_o), .gr_rsel_o(gr_rsel_o), .gr_rdata_i(gr_rdata_i),
		.gr_we_o(gr_we_o), .gr_wsel_o(gr_wsel_o), .gr_wdata_o(gr_wdata_o), .carry_i(carry_i),
		.carry_we_o(carry_we_o), .carry_o(carry_o), .zero_we_o(zero_we_o), .zero_o(zero_o),
		.bus_req_o(bus_req_o), .bus_rdata_i(bus_rdata_i), .bus_ack_i(bus_ack_i),
		.pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .pullup_o(pullup_o));
	bmu_mem_model u_bmu_mem_model (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .req_i(bus_req_o),
		.wait_i(wait_q), .rdata_o(bus_rdata_i), .ack_o(bus_ack_i));
	// Register file writes and flag capture, as the rest of the CPU sees them
	always @(posedge mclk_i)
	begin
		if (gr_we_o && gr_wsel_o[3])
			gr_q[gr_wsel_o[2:0]][7:0] <= gr_wdata_o;
		else if (gr_we_o)
			gr_q[gr_wsel_o[2:0]][15:8] <= gr_wdata_o;
		// Carry flows back into the unit, as the CPU's flag would, so chains are tested
		if (carry_we_o)
		begin
			c_seen <= carry_o;
			carry_i <= carry_o;
		end
		if (zero_we_o)
			z_seen <= zero_o;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
			failures++;
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Offer one or two words back to back, then wait for done or refusal
	task automatic run(input logic [15:0] w1, input logic [15:0] w2, input bit two);
		int n;
		n = 0;
		@(posedge mclk_i);
		instr_valid_i <= 1'b1;
		instr_i <= w1;
		@(posedge mclk_i);
		if (two)
		begin
			instr_i <= w2;
			@(posedge mclk_i);
		end
		instr_valid_i <= 1'b0;
		#1;
		while (done_o !== 1'b1 && illegal_o !== 1'b1 && n < 40)
		begin
			@(posedge mclk_i);
			#1;
			n++;
		end
		got_ill = illegal_o;
		// Judge by the answer itself, so a late answer on the last try still counts
		if (done_o !== 1'b1 && illegal_o !== 1'b1)
		begin
			failures++;
			give_verdict();
		end
		@(posedge mclk_i);
		#1;
	endtask
	// Port latch and direction register through read-modify-write
	task automatic t_port();
		run(16'he0b7, 16'h7000, 1'b1);
		check(pin_o, 8'h41);
		check(pullup_o, 8'h41);
		run(16'he1b5, 16'h7100, 1'b1);
		check(pin_oe_o, 8'hfe);
		// Pin change lands on a clock edge, like every other input
		@(posedge mclk_i);
		pin_i <= 8'h80;
		// Bit 7 drives low although its pin reads high: the latch, not the pin, comes back
		run(16'he0b7, 16'h7010, 1'b1);
		check(pin_o, 8'h42);
		// Bit 0 is an input at low level, so the write-back drops its pull-up
		check(pullup_o, 8'h00);
		run(16'he1b5, 16'h7170, 1'b1);
		check(pin_oe_o, 8'h7f);
		$display("t_port finished");
	endtask
	// Absolute and indirect forms, first at zero and then at two wait states
	task automatic t_mem();
		// Preload on an edge so the unit never sees a mid-cycle change
		@(posedge mclk_i);
		u_bmu_mem_model.mem[8'h10] <= 8'h0a;
		u_bmu_mem_model.mem[8'h20] <= 8'hff;
		gr_q[1] <= 16'h00fb;
		gr_q[2] <= 16'hff20;
		run(16'he010, 16'h7050, 1'b1);
		check(u_bmu_mem_model.mem[8'h10], 8'h2a);
		@(posedge mclk_i);
		wait_q <= 2'h2;
		run(16'hc120, 16'h6190, 1'b1);
		check(u_bmu_mem_model.mem[8'h20], 8'hf7);
		run(16'he220, 16'h7270, 1'b1);
		check(u_bmu_mem_model.mem[8'h20], 8'h77);
		$display("t_mem finished");
	endtask
	// Register-direct forms, immediate and register bit numbers
	task automatic t_reg();
		@(posedge mclk_i);
		gr_q[2] <= 16'h0084;
		run(16'h732a, 16'h0000, 1'b0);
		check(8'(z_seen), 8'h00);
		run(16'h730a, 16'h0000, 1'b0);
		check(8'(z_seen), 8'h01);
		run(16'h777a, 16'h0000, 1'b0);
		check(8'(c_seen), 8'h01);
		run(16'h7c7a, 16'h0000, 1'b0);
		check(8'(c_seen), 8'h00);
		// Carry chain: each step picks a carry where plain and inverted forms disagree
		run(16'h752a, 16'h0000, 1'b0);
		check(8'(c_seen), 8'h01);
		run(16'h740a, 16'h0000, 1'b0);
		check(8'(c_seen), 8'h00);
		run(16'h7a0a, 16'h0000, 1'b0);
		check(8'(c_seen), 8'h01);
		run(16'h792a, 16'h0000, 1'b0);
		check(8'(c_seen), 8'h00);
		run(16'h7b0a, 16'h0000, 1'b0);
		check(8'(c_seen), 8'h01);
		// Store with carry one sets bit 4 of the low byte
		run(16'h784b, 16'h0000, 1'b0);
		check(gr_q[3][7:0], 8'h10);
		run(16'h762a, 16'h0000, 1'b0);
		check(8'(c_seen), 8'h00);
		run(16'h609b, 16'h0000, 1'b0);
		check(gr_q[3][7:0], 8'h18);
		// Inverted store with carry zero sets bit 5
		run(16'h7d5b, 16'h0000, 1'b0);
		check(gr_q[3][7:0], 8'h38);
		$display("t_reg finished");
	endtask
	// Words that must be refused
	task automatic t_bad();
		// Carry ops with register bit, bad op code, bit 7 set, nonzero pointer tail, unknown form
		logic [15:0] bad [6] = '{16'h649b, 16'h6a9b, 16'h7f0a, 16'h738a, 16'hc121, 16'h100a};
		foreach (bad[i])
		begin
			run(bad[i], 16'h0000, 1'b0);
			check(8'(got_ill), 8'h01);
		end
		// Second word whose op field differs from the first word's
		run(16'he010, 16'h7150, 1'b1);
		check(8'(got_ill), 8'h01);
		$display("t_bad finished");
	endtask
	initial
	begin
		foreach (gr_q[i])
			gr_q[i] = 16'h0000;
		repeat (5) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		t_port();
		t_mem();
		t_reg();
		t_bad();
		give_verdict();
	end
endmodule
`default_nettype wire
